// ### hw/tsf_flags.sv
// Per-channel event flags, enables and interrupt requests for a five-channel timer
//
// How it works
// [RL1] Five channels, each with 8-bit event flag and 8-bit enable register.
// [RL2] Flag registers read 0xf8 after reset or standby entry.
// [RL3] Bits 7..3 of both registers read one and ignore writes.
// [RL4] Wrap flag sets on counter wrap up past FFFF or down past 0000.
// [RL5] Downward wrap counts only in phase counting or complementary PWM modes.
// [RL6] Writing one to a flag does nothing; zero only clears.
// [RL7] A zero write clears a flag only after software read it as one.
// [RL8] Flag B sets on compare match with general register B.
// [RL9] Flag B also sets on input capture into general register B.
// [RL10] Flag A sets on compare match or capture of general register A.
// [RL11] Channels 0..3 clear flag A when the DMA takes the A request.
// [RL12] Enable bit 2 gates the wrap flag onto the wrap interrupt.
// [RL13] Enable bit 1 gates flag B onto the B interrupt.
// [RL14] Enable bit 0 gates flag A onto the A interrupt.
// [RL15] Enable registers reset to 0xf8; the three enable bits are read/write.
// [RL16] Counter keeps counting after an upward wrap; the flag never stops it.
// [RL17] Each request is flag AND enable, held as a level.
// [RL18] A set event in the same cycle as a clearing write wins.
`timescale 1ns/10ps
`include "tsf_map.svh"
module tsf_flags (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    clkEn,
  input  wire logic                    standby,
  input  wire logic [`TSF_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [7:0]              regRdata,
  input  wire tsf_pkg::tsf_chvec_t     wrapUp,
  input  wire tsf_pkg::tsf_chvec_t     wrapDown,
  input  wire tsf_pkg::tsf_chvec_t     matchCaptureA,
  input  wire tsf_pkg::tsf_chvec_t     matchCaptureB,
  input  wire tsf_pkg::tsf_chvec_t     dmaAckA,
  output tsf_pkg::tsf_chvec_t          wrapIrq,
  output tsf_pkg::tsf_chvec_t          flagAIrq,
  output tsf_pkg::tsf_chvec_t          flagBIrq,
  output logic                         irqOut
);

  tsf_pkg::tsf_flags_t flags_q [`TSF_NUM_CH];
  tsf_pkg::tsf_flags_t enables_q [`TSF_NUM_CH];
  tsf_pkg::tsf_flags_t seen_q [`TSF_NUM_CH];
  logic [1:0]          mode_q;
  logic [2:0]          irqStat_q;
  logic [2:0]          irqMask_q;
  logic [7:0]          rdata_d;
  logic [2:0]          evt;

  // Channel index of an address inside a 5-register bank, or 7 when outside
  function automatic logic [2:0] chan_of(input logic [`TSF_ADDR_W-1:0] a, input logic [`TSF_ADDR_W-1:0] base);
    logic [`TSF_ADDR_W-1:0] off;
    off = a - base;
    chan_of = (a >= base && off < 5'(`TSF_NUM_CH)) ? off[2:0] : 3'h7;
  endfunction : chan_of

  // Downward wrap only counts while the channel is an up/down counter
  function automatic logic down_ok(input int ch, input logic [1:0] m);
    down_ok = (ch == 2 && m[`TSF_MODE_PHASE]) || ((ch == 3 || ch == 4) && m[`TSF_MODE_CPWM]); // RL5
  endfunction : down_ok

  // Request bits of one channel: flag AND enable
  function automatic tsf_pkg::tsf_flags_t req_of(input tsf_pkg::tsf_flags_t f, input tsf_pkg::tsf_flags_t e);
    req_of = f & e;
  endfunction : req_of

  wire logic [2:0] flagCh = chan_of(regAddr, `TSF_FLAGS_BASE);
  wire logic [2:0] enCh   = chan_of(regAddr, `TSF_ENABLES_BASE);

  // Flags: set wins over clear; standby returns them to reset value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < `TSF_NUM_CH; c++) begin
        flags_q[c] <= 3'h0; // RL2
        seen_q[c]  <= 3'h0;
      end
    end else if (clkEn) begin
      for (int c = 0; c < `TSF_NUM_CH; c++) begin
        if (standby) begin
          flags_q[c] <= 3'h0; // RL2
          seen_q[c]  <= 3'h0;
        end else begin
          tsf_pkg::tsf_flags_t nxt;
          tsf_pkg::tsf_flags_t clr;
          nxt = flags_q[c];
          clr = 3'h0;
          if (regRd && flagCh == 3'(c))
            seen_q[c] <= seen_q[c] | flags_q[c]; // RL7
          if (regWr && flagCh == 3'(c)) begin
            clr = ~regWdata[2:0] & seen_q[c]; // RL6 RL7
            seen_q[c] <= seen_q[c] & regWdata[2:0];
          end
          if (c < 4 && dmaAckA[c])
            clr[`TSF_BIT_A] = 1'b1; // RL11
          nxt = nxt & ~clr;
          nxt[`TSF_BIT_WRAP] = nxt[`TSF_BIT_WRAP] | wrapUp[c] | (wrapDown[c] && down_ok(c, mode_q)); // RL4 RL16 RL18
          nxt[`TSF_BIT_B] = nxt[`TSF_BIT_B] | matchCaptureB[c]; // RL8 RL9 RL18
          nxt[`TSF_BIT_A] = nxt[`TSF_BIT_A] | matchCaptureA[c]; // RL10 RL18
          flags_q[c] <= nxt;
        end
      end
    end
  end

  // Enables
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < `TSF_NUM_CH; c++)
        enables_q[c] <= 3'h0; // RL15
    end else if (clkEn) begin
      for (int c = 0; c < `TSF_NUM_CH; c++) begin
        if (standby)
          enables_q[c] <= 3'h0; // RL15
        else if (regWr && enCh == 3'(c))
          enables_q[c] <= regWdata[2:0]; // RL3 RL15
      end
    end
  end

  // Mode and summary interrupt registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q    <= 2'h0;
      irqMask_q <= 3'h0;
    end else if (clkEn) begin
      if (regWr && regAddr == `TSF_MODE)
        mode_q <= regWdata[1:0];
      if (regWr && regAddr == `TSF_IRQ_MASK)
        irqMask_q <= regWdata[2:0];
    end
  end

  // Summary status: bit per request kind, cleared by read, new events win
  always_comb begin
    evt = 3'h0;
    for (int c = 0; c < `TSF_NUM_CH; c++)
      evt = evt | req_of(flags_q[c], enables_q[c]);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      irqStat_q <= 3'h0;
    else if (clkEn)
      irqStat_q <= ((regRd && regAddr == `TSF_IRQ_STAT) ? 3'h0 : irqStat_q) | evt;
  end

  // Requests: level AND of flag and enable, registered
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrapIrq  <= 5'h0;
      flagAIrq <= 5'h0;
      flagBIrq <= 5'h0;
      irqOut   <= 1'b0;
    end else if (clkEn) begin
      for (int c = 0; c < `TSF_NUM_CH; c++) begin
        wrapIrq[c]  <= flags_q[c][`TSF_BIT_WRAP] & enables_q[c][`TSF_BIT_WRAP]; // RL12 RL17
        flagBIrq[c] <= flags_q[c][`TSF_BIT_B] & enables_q[c][`TSF_BIT_B]; // RL13 RL17
        flagAIrq[c] <= flags_q[c][`TSF_BIT_A] & enables_q[c][`TSF_BIT_A]; // RL14 RL17
      end
      irqOut <= |(irqStat_q & irqMask_q);
    end
  end

  // Read mux; reserved bits of the flag and enable registers read as ones
  always_comb begin
    rdata_d = 8'h00;
    if (flagCh != 3'h7)
      rdata_d = `TSF_RSVD_ONES | {5'h0, flags_q[flagCh]}; // RL1 RL3
    else if (enCh != 3'h7)
      rdata_d = `TSF_RSVD_ONES | {5'h0, enables_q[enCh]}; // RL1 RL3
    else if (regAddr == `TSF_IRQ_STAT)
      rdata_d = {5'h0, irqStat_q};
    else if (regAddr == `TSF_IRQ_MASK)
      rdata_d = {5'h0, irqMask_q};
    else if (regAddr == `TSF_MODE)
      rdata_d = {6'h0, mode_q};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      regRdata <= 8'h00;
    else if (clkEn)
      regRdata <= regRd ? rdata_d : 8'h00;
  end

  property p_flag_reset_val;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && regRd && regAddr == `TSF_FLAGS_BASE)
      |=> regRdata[7:3] == 5'h1f;
  endproperty
  a_flag_reset_val: assert property (p_flag_reset_val) else $error("reserved bits not one"); // RL3

  property p_wrap_set;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && !standby && wrapUp[0]) |=> flags_q[0][`TSF_BIT_WRAP];
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set"); // RL4

  property p_down_blocked;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && !standby && wrapDown[1] && !wrapUp[1]
      && !flags_q[1][`TSF_BIT_WRAP]) |=> !flags_q[1][`TSF_BIT_WRAP];
  endproperty
  a_down_blocked: assert property (p_down_blocked) else $error("channel 1 took a down wrap"); // RL5

  property p_no_clear_unseen;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && !standby && regWr && regAddr == `TSF_FLAGS_BASE + 5'h1
      && flags_q[1][`TSF_BIT_B] && !seen_q[1][`TSF_BIT_B]) |=> flags_q[1][`TSF_BIT_B];
  endproperty
  a_no_clear_unseen: assert property (p_no_clear_unseen) else $error("flag cleared without read"); // RL7

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && !standby && matchCaptureA[2]) |=> flags_q[2][`TSF_BIT_A];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set event lost"); // RL18

  property p_dma_clear;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && !standby && dmaAckA[3] && !matchCaptureA[3])
      |=> !flags_q[3][`TSF_BIT_A];
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("dma did not clear flag A"); // RL11

  property p_irq_b;
    @(posedge sys_clk) disable iff (!rstn) clkEn |=> flagBIrq[0] == $past(flags_q[0][1] & enables_q[0][1]);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("B request wrong"); // RL13

  property p_irq_a_wrap;
    @(posedge sys_clk) disable iff (!rstn) clkEn |=> (flagAIrq[4] == $past(flags_q[4][0] & enables_q[4][0]))
      && (wrapIrq[4] == $past(flags_q[4][2] & enables_q[4][2]));
  endproperty
  a_irq_a_wrap: assert property (p_irq_a_wrap) else $error("A or wrap request wrong"); // RL12

  property p_standby_clear;
    @(posedge sys_clk) disable iff (!rstn) (clkEn && standby) |=> enables_q[0] == 3'h0 && flags_q[0] == 3'h0;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby did not reset"); // RL15

  property p_standby_clear4;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && standby) |=> flags_q[4] == 3'h0 && enables_q[4] == 3'h0;
  endproperty
  a_standby_clear4: assert property (p_standby_clear4) else $error("standby left channel 4 state"); // RL2

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !regRd) |=> regRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // RL1

  property p_rdata_flags;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && regRd && regAddr == `TSF_FLAGS_BASE + 5'h2) |=> regRdata == (`TSF_RSVD_ONES | {5'h0, $past(flags_q[2])});
  endproperty
  a_rdata_flags: assert property (p_rdata_flags) else $error("flag read data wrong"); // RL1

  property p_rdata_en_rsvd;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && regRd && regAddr == `TSF_ENABLES_BASE + 5'h3) |=> regRdata[7:3] == 5'h1f;
  endproperty
  a_rdata_en_rsvd: assert property (p_rdata_en_rsvd) else $error("enable reserved bits not one"); // RL3

  property p_one_no_set;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && regWr && regAddr == `TSF_FLAGS_BASE && regWdata[1] && !flags_q[0][`TSF_BIT_B]
      && !matchCaptureB[0]) |=> !flags_q[0][`TSF_BIT_B];
  endproperty
  a_one_no_set: assert property (p_one_no_set) else $error("write of one set a flag"); // RL6

  property p_b_set0;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureB[0]) |=> flags_q[0][`TSF_BIT_B];
  endproperty
  a_b_set0: assert property (p_b_set0) else $error("flag B of channel 0 not set"); // RL8

  property p_b_set1;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureB[1]) |=> flags_q[1][`TSF_BIT_B];
  endproperty
  a_b_set1: assert property (p_b_set1) else $error("flag B of channel 1 not set"); // RL8

  property p_b_set4;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureB[4]) |=> flags_q[4][`TSF_BIT_B];
  endproperty
  a_b_set4: assert property (p_b_set4) else $error("flag B of channel 4 not set"); // RL9

  property p_a_set0;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureA[0]) |=> flags_q[0][`TSF_BIT_A];
  endproperty
  a_a_set0: assert property (p_a_set0) else $error("flag A of channel 0 not set"); // RL10

  property p_a_set3;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureA[3]) |=> flags_q[3][`TSF_BIT_A];
  endproperty
  a_a_set3: assert property (p_a_set3) else $error("flag A of channel 3 not set"); // RL10

  property p_a_set4;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && matchCaptureA[4]) |=> flags_q[4][`TSF_BIT_A];
  endproperty
  a_a_set4: assert property (p_a_set4) else $error("flag A of channel 4 not set"); // RL10

  // Channel 4 has no DMA path, so a take there must leave flag A alone
  property p_dma_ignored4;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && dmaAckA[4] && flags_q[4][`TSF_BIT_A]
      && !(regWr && regAddr == `TSF_FLAGS_BASE + 5'h4)) |=> flags_q[4][`TSF_BIT_A];
  endproperty
  a_dma_ignored4: assert property (p_dma_ignored4) else $error("dma cleared channel 4 flag A"); // RL11

  property p_down_ch2;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && wrapDown[2] && mode_q[`TSF_MODE_PHASE]) |=> flags_q[2][`TSF_BIT_WRAP];
  endproperty
  a_down_ch2: assert property (p_down_ch2) else $error("channel 2 down wrap lost"); // RL4

  property p_down_ch3_off;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && wrapDown[3] && !wrapUp[3] && !mode_q[`TSF_MODE_CPWM]
      && !flags_q[3][`TSF_BIT_WRAP]) |=> !flags_q[3][`TSF_BIT_WRAP];
  endproperty
  a_down_ch3_off: assert property (p_down_ch3_off) else $error("channel 3 took a down wrap"); // RL5

  property p_wrap_up1;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && wrapUp[1]) |=> flags_q[1][`TSF_BIT_WRAP];
  endproperty
  a_wrap_up1: assert property (p_wrap_up1) else $error("channel 1 wrap flag not set"); // RL16

  property p_wrap_up4;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && wrapUp[4]) |=> flags_q[4][`TSF_BIT_WRAP];
  endproperty
  a_wrap_up4: assert property (p_wrap_up4) else $error("channel 4 wrap flag not set"); // RL4

  property p_irq_wrap0;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn |=> wrapIrq[0] == $past(flags_q[0][2] & enables_q[0][2]);
  endproperty
  a_irq_wrap0: assert property (p_irq_wrap0) else $error("channel 0 wrap request wrong"); // RL12

  property p_irq_wrap2;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn |=> wrapIrq[2] == $past(flags_q[2][2] & enables_q[2][2]);
  endproperty
  a_irq_wrap2: assert property (p_irq_wrap2) else $error("channel 2 wrap request wrong"); // RL12

  property p_irq_a1;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn |=> flagAIrq[1] == $past(flags_q[1][0] & enables_q[1][0]);
  endproperty
  a_irq_a1: assert property (p_irq_a1) else $error("channel 1 A request wrong"); // RL14

  property p_irq_b3;
    @(posedge sys_clk) disable iff (!rstn)
      clkEn |=> flagBIrq[3] == $past(flags_q[3][1] & enables_q[3][1]);
  endproperty
  a_irq_b3: assert property (p_irq_b3) else $error("channel 3 B request wrong"); // RL13

  // A frozen block must hold its request levels, not drop them
  property p_irq_frozen;
    @(posedge sys_clk) disable iff (!rstn)
      !clkEn |=> $stable(wrapIrq) && $stable(flagAIrq) && $stable(flagBIrq);
  endproperty
  a_irq_frozen: assert property (p_irq_frozen) else $error("requests moved while frozen"); // RL17

  property p_seen_needed;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && regWr && regAddr == `TSF_FLAGS_BASE + 5'h3 && flags_q[3][`TSF_BIT_A]
      && !seen_q[3][`TSF_BIT_A] && !dmaAckA[3]) |=> flags_q[3][`TSF_BIT_A];
  endproperty
  a_seen_needed: assert property (p_seen_needed) else $error("flag A cleared without read"); // RL7

  property p_clear_after_read;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && regWr && regAddr == `TSF_FLAGS_BASE + 5'h1 && !regWdata[1]
      && seen_q[1][`TSF_BIT_B] && !matchCaptureB[1]) |=> !flags_q[1][`TSF_BIT_B];
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("read then zero did not clear"); // RL7

  property p_en_write;
    @(posedge sys_clk) disable iff (!rstn)
      (clkEn && !standby && regWr && regAddr == `TSF_ENABLES_BASE + 5'h2) |=> enables_q[2] == $past(regWdata[2:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost"); // RL15

endmodule : tsf_flags

// ### hw/tsf_map.svh
// Register offsets, field positions, reset values and counts for the timer status/interrupt flag block
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH
`define TSF_NUM_CH        5
`define TSF_ADDR_W        5
`define TSF_FLAGS_BASE    5'h00
`define TSF_ENABLES_BASE  5'h08
`define TSF_IRQ_STAT      5'h10
`define TSF_IRQ_MASK      5'h11
`define TSF_MODE          5'h12
`define TSF_REG_RESET     8'hf8
`define TSF_RSVD_ONES     8'hf8
`define TSF_BIT_WRAP      2
`define TSF_BIT_B         1
`define TSF_BIT_A         0
`define TSF_DMA_CH_MASK   5'h0f
`define TSF_MODE_PHASE    0
`define TSF_MODE_CPWM     1
`endif

// ### hw/tsf_pkg.sv
// Types for the timer status/interrupt flag block
package tsf_pkg;
  typedef logic [2:0] tsf_flags_t;
  typedef logic [4:0] tsf_chvec_t;
endpackage : tsf_pkg

// ### tb/tsf_dma_model.sv
// DMA side model: takes each channel's A request with a one-cycle pulse
`timescale 1ns/10ps
module tsf_dma_model (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                dmaOn,
  input  wire tsf_pkg::tsf_chvec_t flagAIrq,
  output tsf_pkg::tsf_chvec_t      dmaAckA
);
  // Backs off a cycle after each take, so a request still standing is taken again
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dmaAckA <= '0;
    end else begin
      dmaAckA <= dmaOn ? (flagAIrq & ~dmaAckA) : '0;
    end
  end
endmodule : tsf_dma_model

// ### tb/tsf_flags_tb.sv
// Self-checking bench for the timer flag block
`timescale 1ns/10ps
`include "tsf_map.svh"
module tsf_flags_tb;
  logic                sys_clk, rstn, clkEn, standby, regWr, regRd, dmaOn, irqOut;
  logic [4:0]          regAddr;
  logic [7:0]          regWdata, regRdata;
  tsf_pkg::tsf_chvec_t wrapUp, wrapDown, mcA, mcB, dmaAckA, wrapIrq, flagAIrq, flagBIrq;
  int                  errors, num_checks, cyc;
  tsf_flags i_dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .standby(standby),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .wrapUp(wrapUp), .wrapDown(wrapDown), .matchCaptureA(mcA), .matchCaptureB(mcB),
    .dmaAckA(dmaAckA), .wrapIrq(wrapIrq), .flagAIrq(flagAIrq), .flagBIrq(flagBIrq), .irqOut(irqOut));
  tsf_dma_model i_dma (.sys_clk(sys_clk), .rstn(rstn), .dmaOn(dmaOn), .flagAIrq(flagAIrq),
    .dmaAckA(dmaAckA));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [4:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
    @(posedge sys_clk);
  endtask : rd
  task ev(input logic [4:0] w, input logic [4:0] d, input logic [4:0] a, input logic [4:0] b);
    wrapUp <= w;
    wrapDown <= d;
    mcA <= a;
    mcB <= b;
    @(posedge sys_clk);
    {wrapUp, wrapDown, mcA, mcB} <= '0;
    @(posedge sys_clk);
  endtask : ev
  task irq0(input logic [7:0] exp);
    #1 chk({5'h00, wrapIrq[0], flagBIrq[0], flagAIrq[0]}, exp);
  endtask : irq0
  task conclude;
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    {rstn, standby, regWr, regRd, dmaOn, regAddr, regWdata} = '0;
    {wrapUp, wrapDown, mcA, mcB} = '0;
    clkEn = 1'b1;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int c = 0; c < `TSF_NUM_CH; c++) begin
      rd(`TSF_FLAGS_BASE + 5'(c), `TSF_REG_RESET);
      rd(`TSF_ENABLES_BASE + 5'(c), `TSF_REG_RESET);
    end
    rd(5'h1f, 8'h00);
    ev(5'h02, 5'h00, 5'h02, 5'h02);
    wr(5'h01, 8'hf8);
    rd(5'h01, 8'hff);
    wr(5'h01, 8'hf8);
    rd(5'h01, 8'hf8);
    wr(5'h01, 8'hff);
    rd(5'h01, 8'hf8);
    wr(5'h08, 8'h07);
    rd(5'h08, 8'hff);
    ev(5'h01, 5'h00, 5'h01, 5'h01);
    irq0(8'h07);
    wr(5'h08, 8'h06);
    irq0(8'h06);
    wr(5'h08, 8'h01);
    irq0(8'h01);
    wr(`TSF_IRQ_MASK, 8'h07);
    #1 chk({7'h00, irqOut}, 8'h01);
    wr(5'h08, 8'h00);
    rd(`TSF_IRQ_STAT, 8'h07);
    #1 chk({7'h00, irqOut}, 8'h00);
    ev(5'h00, 5'h0f, 5'h00, 5'h00);
    rd(5'h00, 8'hff);
    rd(5'h01, 8'hf8);
    rd(5'h02, 8'hf8);
    wr(`TSF_MODE, 8'h01);
    ev(5'h00, 5'h04, 5'h00, 5'h00);
    rd(5'h02, 8'hfc);
    wr(5'h00, 8'hf8);
    rd(5'h00, 8'hf8);
    ev(5'h00, 5'h00, 5'h01, 5'h00);
    rd(5'h00, 8'hf9);
    regAddr <= 5'h00;
    regWdata <= 8'hf8;
    regWr <= 1'b1;
    mcA <= 5'h05;
    @(posedge sys_clk);
    regWr <= 1'b0;
    mcA <= 5'h00;
    @(posedge sys_clk);
    rd(5'h00, 8'hf9);
    wr(5'h0b, 8'h01);
    wr(5'h0c, 8'h01);
    dmaOn <= 1'b1;
    ev(5'h00, 5'h00, 5'h18, 5'h00);
    repeat (4) @(posedge sys_clk);
    rd(5'h03, 8'hf8);
    rd(5'h04, 8'hf9);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    @(posedge sys_clk);
    rd(5'h04, 8'hf8);
    rd(5'h08, 8'hf8);
    clkEn <= 1'b0;
    mcA <= 5'h02;
    repeat (2) @(posedge sys_clk);
    clkEn <= 1'b1;
    mcA <= 5'h00;
    @(posedge sys_clk);
    rd(5'h01, 8'hf8);
    conclude();
  end
endmodule : tsf_flags_tb
